// ### pmp_pkg.sv
package pmp_pkg;
   // Register byte offsets on the bus
   localparam logic [7:0] PMP_CTRL_OFS = 8'h00;
   localparam logic [7:0] PMP_MODE_OFS = 8'h04;
   localparam logic [7:0] PMP_ADDR_OFS = 8'h08;
   localparam logic [7:0] PMP_PINEN_OFS = 8'h0c;
   localparam logic [7:0] PMP_STAT_OFS = 8'h10;
   localparam logic [7:0] PMP_PAD_OFS = 8'h14;
   localparam logic [7:0] PMP_OUT1_OFS = 8'h18;
   localparam logic [7:0] PMP_OUT2_OFS = 8'h1c;
   localparam logic [7:0] PMP_IN1_OFS = 8'h20;
   localparam logic [7:0] PMP_IN2_OFS = 8'h24;
   localparam logic [7:0] PMP_MDATA_OFS = 8'h28;
   localparam logic [7:0] PMP_CMD_OFS = 8'h2c;
   localparam logic [7:0] PMP_IRQ_OFS = 8'h30;
   localparam logic [7:0] PMP_IMASK_OFS = 8'h34;
   // Control field positions
   localparam int PMP_READ_STROBE_POLARITY_BIT = 0;
   localparam int PMP_WRITE_STROBE_POLARITY_BIT = 1;
   localparam int PMP_BEP_BIT = 2;
   localparam int PMP_CS1P_BIT = 3;
   localparam int PMP_CS2P_BIT = 4;
   localparam int PMP_ALP_BIT = 5;
   localparam int PMP_EN_BIT = 15;
   // Mode field positions
   localparam int PMP_END_PHASE_WAIT_LSB = 0;
   localparam int PMP_MIDDLE_PHASE_WAIT_LSB = 2;
   localparam int PMP_ADDRESS_PHASE_WAIT_LSB = 6;
   localparam int PMP_MODE_LSB = 8;
   localparam int PMP_IRQM_LSB = 13;
   localparam int PMP_BUSY_BIT = 15;
   localparam logic [1:0] PMP_MODE_MASTER1 = 2'b11;
   localparam logic [1:0] PMP_MODE_MASTER2 = 2'b10;
   localparam logic [1:0] PMP_MODE_SLAVE_ADDR = 2'b01;
   localparam logic [1:0] PMP_IRQM_CYCLE = 2'b01;
   localparam logic [1:0] PMP_IRQM_BUFFER = 2'b10;
   // Reset values
   localparam logic [15:0] PMP_ZERO_RST = 16'h0000;
   localparam logic [3:0] PMP_OBE_RST = 4'hf;
   // Interrupt status bit positions
   localparam int PMP_IRQ_CYCLE = 0;
   localparam int PMP_IRQ_INOVF = 1;
   localparam int PMP_IRQ_OUTUNF = 2;
   localparam int PMP_IRQ_BUF = 3;
   // Timing: one instruction cycle gap between operations, taken as 63 ns
   localparam int PMP_TCY_NS = 63;
   localparam int PMP_CLK_NS = 5;
   localparam int PMP_TCY_CYC = (PMP_TCY_NS + PMP_CLK_NS - 1) / PMP_CLK_NS;
   // AXI responses
   localparam logic [1:0] PMP_RESP_OKAY = 2'b00;
   localparam logic [1:0] PMP_RESP_SLVERR = 2'b10;

   typedef enum {PMP_IDLE, PMP_ADPH, PMP_MID, PMP_END, PMP_GAP} pmp_state_e;

   // Master cycle request
   typedef struct packed {
      logic wr;
      logic [15:0] addr;
      logic [7:0] data;
   } pmp_req_s;
endpackage

// ### pmp_buf.sv
`timescale 1ns/1ps
// Four-byte slave buffer with registered read data
module pmp_buf
   import pmp_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic resetn,
   // Write port
   input wire logic we,
   input wire logic [1:0] waddr,
   input wire logic [7:0] wdata,
   // Read port
   input wire logic [1:0] raddr,
   output logic [7:0] rdata,
   output logic [31:0] all_data
);
   logic [7:0] mem_reg [4];

   // Byte storage
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         for (int i = 0; i < 4; i++) begin
            mem_reg[i] <= 8'h00;
         end
      end else if (we) begin
         mem_reg[waddr] <= wdata;
      end
   end

   // Registered read
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         rdata <= 8'h00;
      end else begin
         rdata <= mem_reg[raddr];
      end
   end

   assign all_data = {mem_reg[3], mem_reg[2], mem_reg[1], mem_reg[0]};
endmodule

// ### pmp_top.sv
// Chosen here: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
// Functional notes
// RULE1: Byte enable polarity follows its control bit
// RULE2: Write polarity sets enable strobe in mode 11
// RULE3: Read polarity sets combined strobe in mode 11
// RULE4: Latch and select polarity ignored on address pins; code applies CS polarity, ALP unless middle wait 0
// RULE5: Interrupt mode 01 fires per completed cycle
// RULE6: Zero middle wait disables other waits
// RULE7: One instruction cycle between port operations
// RULE8: Address field plus two chip select bits
// RULE9: Top pins address or chip select when enabled
// RULE10: Pins 13 to 2 address when enabled
// RULE11: Pins 1 and 0 address or latch strobes
// RULE12: Inputs full only when all bytes full
// RULE13: Per-byte full set by host, cleared by read
// RULE14: Two low address lines pick buffer byte
// RULE15: Busy high during master cycle
// RULE16: Sticky overflow and underflow, software cleared
// RULE17: Output empty set by host read, cleared by write
module pmp_top
   import pmp_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic resetn,
   // AXI4-Lite write channels
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read channels
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Address pins
   output logic [15:0] parallel_address_lines,
   output logic [15:0] addr_pin_oe,
   // Data pins
   input wire logic [7:0] parallel_data_in,
   output logic [7:0] parallel_data_lines,
   output logic parallel_data_oe,
   // Strobes
   output logic read_strobe_pin,
   output logic write_strobe_pin,
   output logic byte_enable_pin,
   // Slave-side host strobes
   input wire logic host_cs,
   input wire logic host_rd,
   input wire logic host_wr,
   input wire logic [1:0] host_addr,
   // Interrupt
   output logic irq
);
   logic [15:0] ctrl_reg, mode_reg, addr_reg, pinen_reg, pad_reg;
   logic [7:0] mdata_reg;
   logic [3:0] ist_reg, imask_reg;
   logic [3:0] inf_reg, obe_reg;
   logic inovf_reg, outunf_reg;
   logic [31:0] outbuf_reg;
   pmp_state_e state_reg;
   pmp_req_s req_reg;
   logic [3:0] cnt_reg;
   logic busy, busy_reg;
   logic [1:0] pmode;
   logic cyc_done;
   // Bus-side holding
   logic aw_hold, w_hold, ar_pend;
   logic [7:0] aw_addr_reg, ar_addr_reg;
   logic [31:0] w_data_reg;
   logic wr_fire, rd_fire;
   logic [31:0] rd_data;
   logic rd_ok, wr_ok;
   // Host side
   logic host_wr_d, host_rd_d, host_wr_ev, host_rd_ev;
   logic [31:0] inbuf_all;
   logic [7:0] out_byte_q;
   logic cmd_start, cmd_wr;
   logic sw_rd_in1, sw_rd_in2;

   function automatic logic known_ofs(input logic [7:0] a);
      known_ofs = (a <= PMP_IMASK_OFS) && (a[1:0] == 2'b00);
   endfunction

   assign pmode = mode_reg[PMP_MODE_LSB +: 2];
   assign busy = (state_reg != PMP_IDLE) && (state_reg != PMP_GAP);

   // Write address and data capture, either order
   assign s_axi_awready = !aw_hold && !s_axi_bvalid;
   assign s_axi_wready = !w_hold && !s_axi_bvalid;
   assign wr_fire = aw_hold && w_hold && !s_axi_bvalid;
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         aw_hold <= 1'b0;
         w_hold <= 1'b0;
         aw_addr_reg <= 8'h00;
         w_data_reg <= 32'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= PMP_RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_hold <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_hold <= 1'b1;
            w_data_reg <= s_axi_wdata;
         end
         if (wr_fire) begin
            aw_hold <= 1'b0;
            w_hold <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_ok ? PMP_RESP_OKAY : PMP_RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end
   assign wr_ok = known_ofs(aw_addr_reg);

   // Software register writes
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         ctrl_reg <= PMP_ZERO_RST;
         mode_reg <= PMP_ZERO_RST;
         addr_reg <= PMP_ZERO_RST;
         pinen_reg <= PMP_ZERO_RST;
         pad_reg <= PMP_ZERO_RST;
         mdata_reg <= 8'h00;
         imask_reg <= 4'h0;
      end else if (wr_fire) begin
         case (aw_addr_reg)
            PMP_CTRL_OFS: ctrl_reg <= w_data_reg[15:0];
            PMP_MODE_OFS: mode_reg[14:0] <= w_data_reg[14:0];
            PMP_ADDR_OFS: addr_reg <= w_data_reg[15:0]; // RULE8
            PMP_PINEN_OFS: pinen_reg <= w_data_reg[15:0];
            PMP_PAD_OFS: pad_reg <= {14'h0, w_data_reg[1:0]};
            PMP_MDATA_OFS: mdata_reg <= w_data_reg[7:0];
            PMP_IMASK_OFS: imask_reg <= w_data_reg[3:0];
            default: ;
         endcase
      end
   end

   // Outbound buffer words written by software
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         outbuf_reg <= 32'h0;
      end else if (wr_fire && aw_addr_reg == PMP_OUT1_OFS) begin
         outbuf_reg[15:0] <= w_data_reg[15:0];
      end else if (wr_fire && aw_addr_reg == PMP_OUT2_OFS) begin
         outbuf_reg[31:16] <= w_data_reg[15:0];
      end
   end

   assign cmd_start = wr_fire && aw_addr_reg == PMP_CMD_OFS && ctrl_reg[PMP_EN_BIT];
   assign cmd_wr = w_data_reg[0];

   // Master cycle sequencer with wait phases
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         state_reg <= PMP_IDLE;
         cnt_reg <= 4'h0;
         req_reg <= '0;
      end else begin
         case (state_reg)
            PMP_IDLE: begin
               if (cmd_start && pmode[1]) begin
                  req_reg <= '{wr: cmd_wr, addr: addr_reg, data: mdata_reg};
                  if (mode_reg[PMP_MIDDLE_PHASE_WAIT_LSB +: 4] == 4'h0) begin // RULE6
                     state_reg <= PMP_MID;
                     cnt_reg <= 4'h0;
                  end else begin
                     state_reg <= PMP_ADPH;
                     cnt_reg <= {2'b00, mode_reg[PMP_ADDRESS_PHASE_WAIT_LSB +: 2]};
                  end
               end
            end
            PMP_ADPH: begin
               if (cnt_reg == 4'h0) begin
                  state_reg <= PMP_MID;
                  cnt_reg <= mode_reg[PMP_MIDDLE_PHASE_WAIT_LSB +: 4];
               end else begin
                  cnt_reg <= cnt_reg - 4'h1;
               end
            end
            PMP_MID: begin
               if (cnt_reg != 4'h0) begin
                  cnt_reg <= cnt_reg - 4'h1;
               end else if (mode_reg[PMP_MIDDLE_PHASE_WAIT_LSB +: 4] == 4'h0) begin // RULE6
                  state_reg <= PMP_GAP;
                  cnt_reg <= 4'(PMP_TCY_CYC);
               end else begin
                  state_reg <= PMP_END;
                  cnt_reg <= {2'b00, mode_reg[PMP_END_PHASE_WAIT_LSB +: 2]};
               end
            end
            PMP_END: begin
               if (cnt_reg == 4'h0) begin
                  state_reg <= PMP_GAP;
                  cnt_reg <= 4'(PMP_TCY_CYC); // RULE7
               end else begin
                  cnt_reg <= cnt_reg - 4'h1;
               end
            end
            PMP_GAP: begin
               if (cnt_reg <= 4'h1) state_reg <= PMP_IDLE; // RULE7
               else cnt_reg <= cnt_reg - 4'h1;
            end
            default: state_reg <= PMP_IDLE;
         endcase
      end
   end
   assign cyc_done = (state_reg != PMP_GAP) && (state_reg != PMP_IDLE)
      && cnt_reg == 4'h0 && ((state_reg == PMP_END)
      || (state_reg == PMP_MID && mode_reg[PMP_MIDDLE_PHASE_WAIT_LSB +: 4] == 4'h0));

   // Read-only busy flag tracks the running cycle
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         busy_reg <= 1'b0;
      end else begin
         busy_reg <= busy; // RULE15
      end
   end

   // Pin drive: polarity and pin function
   always_comb begin
      logic strobe_on, rd_pol, wr_pol;
      strobe_on = (state_reg == PMP_MID);
      rd_pol = ctrl_reg[PMP_READ_STROBE_POLARITY_BIT];
      wr_pol = ctrl_reg[PMP_WRITE_STROBE_POLARITY_BIT];
      parallel_address_lines = req_reg.addr & {2'b00, 14'h3fff}; // RULE8
      // Chip selects on top pins use their own polarity bits
      parallel_address_lines[15] = req_reg.addr[15] ~^ ctrl_reg[PMP_CS2P_BIT]; // RULE8
      parallel_address_lines[14] = req_reg.addr[14] ~^ ctrl_reg[PMP_CS1P_BIT]; // RULE8
      if (state_reg == PMP_ADPH) begin
         parallel_address_lines[1:0] = {2{ctrl_reg[PMP_ALP_BIT]}}; // RULE11
      end else if (state_reg == PMP_IDLE) begin
         parallel_address_lines[1:0] = {2{~ctrl_reg[PMP_ALP_BIT]}}; // RULE11
      end
      // Wait-free cycles drive true address bits on pins 1 and 0
      if (mode_reg[PMP_MIDDLE_PHASE_WAIT_LSB +: 4] == 4'h0) begin
         parallel_address_lines[1:0] = req_reg.addr[1:0]; // RULE4
      end
      addr_pin_oe = pinen_reg; // RULE9 RULE10 RULE11
      if (pmode == PMP_MODE_MASTER1) begin
         write_strobe_pin = strobe_on ? wr_pol : ~wr_pol; // RULE2
         read_strobe_pin = req_reg.wr ? ~rd_pol : rd_pol; // RULE3
      end else begin
         write_strobe_pin = (strobe_on && req_reg.wr) ? wr_pol : ~wr_pol; // RULE2
         read_strobe_pin = (strobe_on && !req_reg.wr) ? rd_pol : ~rd_pol; // RULE3
      end
      byte_enable_pin = busy ? ctrl_reg[PMP_BEP_BIT] : ~ctrl_reg[PMP_BEP_BIT]; // RULE1
   end

   // Data pin drive
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         parallel_data_lines <= 8'h00;
         parallel_data_oe <= 1'b0;
      end else if (pmode[1]) begin
         parallel_data_lines <= req_reg.data;
         parallel_data_oe <= busy && req_reg.wr;
      end else begin
         parallel_data_lines <= out_byte_q;
         parallel_data_oe <= host_cs && host_rd;
      end
   end

   // Host strobe edges in slave modes
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         host_wr_d <= 1'b0;
         host_rd_d <= 1'b0;
      end else begin
         host_wr_d <= host_cs && host_wr;
         host_rd_d <= host_cs && host_rd;
      end
   end
   assign host_wr_ev = host_cs && host_wr && !host_wr_d && !pmode[1];
   assign host_rd_ev = !(host_cs && host_rd) && host_rd_d && !pmode[1];

   // Inbound buffer written by host
   pmp_buf pmp_buf_inst (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .we(host_wr_ev),
      .waddr(host_addr), // RULE14
      .wdata(parallel_data_in),
      .raddr(2'b00),
      .rdata(),
      .all_data(inbuf_all)
   );
   assign out_byte_q = outbuf_reg[{host_addr, 3'b000} +: 8]; // RULE14

   assign sw_rd_in1 = s_axi_arvalid && s_axi_arready && s_axi_araddr == PMP_IN1_OFS;
   assign sw_rd_in2 = s_axi_arvalid && s_axi_arready && s_axi_araddr == PMP_IN2_OFS;

   // Buffer status flags; hardware set wins over clear
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         inf_reg <= 4'h0;
         obe_reg <= PMP_OBE_RST;
         inovf_reg <= 1'b0;
         outunf_reg <= 1'b0;
      end else begin
         for (int i = 0; i < 4; i++) begin
            if (host_wr_ev && host_addr == 2'(i)) inf_reg[i] <= 1'b1; // RULE13
            else if ((sw_rd_in1 && i < 2) || (sw_rd_in2 && i >= 2)) inf_reg[i] <= 1'b0;
            if (host_rd_ev && host_addr == 2'(i)) obe_reg[i] <= 1'b1; // RULE17
            else if (wr_fire && ((aw_addr_reg == PMP_OUT1_OFS && i < 2)
               || (aw_addr_reg == PMP_OUT2_OFS && i >= 2))) obe_reg[i] <= 1'b0; // RULE17
         end
         if (host_wr_ev && inf_reg[host_addr]) inovf_reg <= 1'b1; // RULE16
         else if (wr_fire && aw_addr_reg == PMP_STAT_OFS && !w_data_reg[14]) inovf_reg <= 1'b0;
         if (host_rd_ev && obe_reg[host_addr]) outunf_reg <= 1'b1; // RULE16
         else if (wr_fire && aw_addr_reg == PMP_STAT_OFS && !w_data_reg[6]) outunf_reg <= 1'b0;
      end
   end

   // Interrupt status, write one to clear, set wins
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         ist_reg <= 4'h0;
      end else begin
         for (int i = 0; i < 4; i++) begin
            if ((i == PMP_IRQ_CYCLE && cyc_done
                  && mode_reg[PMP_IRQM_LSB +: 2] == PMP_IRQM_CYCLE) // RULE5
               || (i == PMP_IRQ_INOVF && host_wr_ev && inf_reg[host_addr])
               || (i == PMP_IRQ_OUTUNF && host_rd_ev && obe_reg[host_addr])
               || (i == PMP_IRQ_BUF && host_wr_ev
                  && mode_reg[PMP_IRQM_LSB +: 2] == PMP_IRQM_BUFFER)) begin
               ist_reg[i] <= 1'b1;
            end else if (wr_fire && aw_addr_reg == PMP_IRQ_OFS && w_data_reg[i]) begin
               ist_reg[i] <= 1'b0;
            end
         end
      end
   end
   assign irq = |(ist_reg & imask_reg);

   // Read channel
   assign s_axi_arready = !ar_pend && !s_axi_rvalid;
   always_comb begin
      rd_data = 32'h0;
      case (ar_addr_reg)
         PMP_CTRL_OFS: rd_data = {16'h0, ctrl_reg};
         PMP_MODE_OFS: rd_data = {16'h0, busy_reg, mode_reg[14:0]};
         PMP_ADDR_OFS: rd_data = {16'h0, addr_reg};
         PMP_PINEN_OFS: rd_data = {16'h0, pinen_reg};
         PMP_STAT_OFS: rd_data = {16'h0, &inf_reg, inovf_reg, 2'b00, inf_reg, // RULE12
            &obe_reg, outunf_reg, 2'b00, obe_reg};
         PMP_PAD_OFS: rd_data = {16'h0, pad_reg};
         PMP_OUT1_OFS: rd_data = {16'h0, outbuf_reg[15:0]};
         PMP_OUT2_OFS: rd_data = {16'h0, outbuf_reg[31:16]};
         PMP_IN1_OFS: rd_data = {16'h0, inbuf_all[15:0]};
         PMP_IN2_OFS: rd_data = {16'h0, inbuf_all[31:16]};
         PMP_MDATA_OFS: rd_data = {24'h0, mdata_reg};
         PMP_IRQ_OFS: rd_data = {28'h0, ist_reg};
         PMP_IMASK_OFS: rd_data = {28'h0, imask_reg};
         default: rd_data = 32'h0;
      endcase
   end
   assign rd_ok = known_ofs(ar_addr_reg);
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         ar_pend <= 1'b0;
         ar_addr_reg <= 8'h00;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= PMP_RESP_OKAY;
      end else begin
         if (s_axi_arvalid && s_axi_arready) begin
            ar_pend <= 1'b1;
            ar_addr_reg <= s_axi_araddr;
         end
         if (ar_pend) begin
            ar_pend <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_data;
            s_axi_rresp <= rd_ok ? PMP_RESP_OKAY : PMP_RESP_SLVERR;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // Checks
   busy_flag_a: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE15
      busy |=> busy_reg) else $error("busy flag not set");
   gap_after_a: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE7
      $fell(busy) |-> !busy [*8]) else $error("no gap between cycles");
   irq_cycle_a: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE5
      cyc_done && mode_reg[PMP_IRQM_LSB +: 2] == PMP_IRQM_CYCLE |=> ist_reg[PMP_IRQ_CYCLE])
      else $error("cycle interrupt missing");
   full_all_a: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE12
      ar_pend && ar_addr_reg == PMP_STAT_OFS |=> s_axi_rdata[15] == ($past(inf_reg) == 4'hf))
      else $error("full flag wrong");
   in_flag_a: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE13
      host_wr_ev |=> inf_reg[$past(host_addr)]) else $error("in flag not set");
   out_flag_a: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE17
      host_rd_ev |=> obe_reg[$past(host_addr)]) else $error("out flag not set");
   ovf_sticky_a: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE16
      inovf_reg && !(wr_fire && aw_addr_reg == PMP_STAT_OFS) |=> inovf_reg)
      else $error("overflow lost");
   be_pol_a: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE1
      busy |-> byte_enable_pin == ctrl_reg[PMP_BEP_BIT])
      else $error("byte enable polarity");
   cyc_cov_c: cover property (@(posedge sys_clk) disable iff (!resetn) cyc_done);
   host_cov_c: cover property (@(posedge sys_clk) disable iff (!resetn) host_wr_ev);
   irq_cov_c: cover property (@(posedge sys_clk) disable iff (!resetn) irq);
endmodule

// ### pmp_host_model.sv
`timescale 1ns/1ps
// External host processor on the slave-side strobes and data bus
module pmp_host_model (
   // Clock
   input wire logic sys_clk,
   // Host strobes
   output logic host_cs,
   output logic host_rd,
   output logic host_wr,
   output logic [1:0] host_addr,
   // Data bus
   output logic [7:0] parallel_data_in,
   input wire logic [7:0] parallel_data_lines
);
   // Idle strobes at time zero
   initial begin
      host_cs = 1'b0;
      host_rd = 1'b0;
      host_wr = 1'b0;
      host_addr = 2'b00;
      parallel_data_in = 8'h00;
   end

   // One host byte transfer, strobes held three cycles
   task automatic host_xfer(input logic wr, input logic [1:0] sel, input logic [7:0] d,
         output logic [7:0] q);
      host_cs <= 1'b1;
      host_rd <= !wr;
      host_wr <= wr;
      host_addr <= sel;
      parallel_data_in <= d;
      repeat (2) @(posedge sys_clk);
      @(negedge sys_clk);
      q = parallel_data_lines; // Settled value, taken before the third edge
      @(posedge sys_clk);
      host_cs <= 1'b0;
      host_rd <= 1'b0;
      host_wr <= 1'b0;
      parallel_data_in <= ~d; // Released bus shows no stale value
      @(posedge sys_clk);
   endtask
endmodule

// ### pmp_top_test.sv
`timescale 1ns/1ps
module pmp_top_test;
   import pmp_pkg::*;
   logic sys_clk = 1'b0, resetn = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, host_addr, r;
   logic [15:0] parallel_address_lines, addr_pin_oe, seen;
   logic [7:0] parallel_data_in, parallel_data_lines, hq, md;
   logic parallel_data_oe, read_strobe_pin, write_strobe_pin, byte_enable_pin;
   logic host_cs, host_rd, host_wr, irq;
   logic [31:0] q;
   int n_mismatch = 0, samples_checked = 0;

   pmp_top pmp_top_inst (.*);
   pmp_host_model pmp_host_model_inst (.*);

   // Clock at 200 MHz
   always #2.5 sys_clk = ~sys_clk;

   task automatic end_of_test();
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] seen_v, input logic [31:0] exp_v);
      samples_checked++;
      if (seen_v !== exp_v) begin
         n_mismatch++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen_v, exp_v);
      end
   endtask

   // Write: address and data offered together, each released when taken
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] rs);
      int n;
      logic aw_hs, w_hs, b_hs;
      n = 0;
      b_hs = 1'b0;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!b_hs && n < 100) begin
         @(negedge sys_clk);
         aw_hs = s_axi_awvalid && s_axi_awready;
         w_hs = s_axi_wvalid && s_axi_wready;
         b_hs = s_axi_bvalid && s_axi_bready;
         rs = s_axi_bresp;
         @(posedge sys_clk);
         if (aw_hs) s_axi_awvalid <= 1'b0;
         if (w_hs) s_axi_wvalid <= 1'b0;
         if (b_hs) s_axi_bready <= 1'b0;
         n++;
      end
      @(posedge sys_clk); // One edge between requests
      if (!b_hs) begin
         n_mismatch++;
         end_of_test();
      end
   endtask

   // Read: address held until taken, rready until data arrives
   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rs);
      int n;
      logic ar_hs, r_hs;
      n = 0;
      r_hs = 1'b0;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      while (!r_hs && n < 100) begin
         @(negedge sys_clk);
         ar_hs = s_axi_arvalid && s_axi_arready;
         r_hs = s_axi_rvalid && s_axi_rready;
         d = s_axi_rdata;
         rs = s_axi_rresp;
         @(posedge sys_clk);
         if (ar_hs) s_axi_arvalid <= 1'b0;
         if (r_hs) s_axi_rready <= 1'b0;
         n++;
      end
      @(posedge sys_clk); // One edge between requests
      if (!r_hs) begin
         n_mismatch++;
         end_of_test();
      end
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp_v);
      axi_rd(a, q, r);
      check(q, exp_v);
   endtask

   initial begin
      repeat (12) @(posedge sys_clk);
      resetn <= 1'b1;
      // Reset values and unmapped place
      rd_chk(PMP_STAT_OFS, 32'h0000_008f);
      rd_chk(PMP_MODE_OFS, 32'h0);
      check({read_strobe_pin, write_strobe_pin, byte_enable_pin}, 3'b111);
      axi_rd(8'h3c, q, r);
      check(q, 32'h0);
      check(r, PMP_RESP_SLVERR);
      axi_wr(8'h3c, 32'h1, r);
      check(r, PMP_RESP_SLVERR);
      // Strobe polarities, master mode 2 then master mode 1
      axi_wr(PMP_MODE_OFS, 32'h0000_0200, r);
      axi_wr(PMP_CTRL_OFS, 32'h0000_0007, r);
      check({read_strobe_pin, write_strobe_pin, byte_enable_pin}, 3'b000);
      axi_wr(PMP_MODE_OFS, 32'h0000_0300, r);
      axi_wr(PMP_CTRL_OFS, 32'h0000_0005, r);
      check({read_strobe_pin, write_strobe_pin, byte_enable_pin}, 3'b110);
      // Addressable slave: fill input bytes, overflow, drain
      axi_wr(PMP_MODE_OFS, 32'h0000_0100, r);
      axi_wr(PMP_CTRL_OFS, 32'h0000_8000, r);
      for (int i = 0; i < 4; i++) begin
         pmp_host_model_inst.host_xfer(1'b1, 2'(i), 8'h10 + 8'(i), hq);
         if (i == 2) rd_chk(PMP_STAT_OFS, 32'h0000_078f);
      end
      rd_chk(PMP_STAT_OFS, 32'h0000_8f8f);
      pmp_host_model_inst.host_xfer(1'b1, 2'b11, 8'h55, hq);
      rd_chk(PMP_STAT_OFS, 32'h0000_cf8f);
      rd_chk(PMP_IN1_OFS, 32'h0000_1110);
      rd_chk(PMP_STAT_OFS, 32'h0000_4c8f);
      axi_wr(PMP_STAT_OFS, 32'h0, r);
      rd_chk(PMP_STAT_OFS, 32'h0000_0c8f);
      // Output bytes: load, host reads, then underflow
      axi_wr(PMP_OUT1_OFS, 32'h0000_2211, r);
      rd_chk(PMP_STAT_OFS, 32'h0000_0c0c);
      pmp_host_model_inst.host_xfer(1'b0, 2'b01, 8'h00, hq);
      check(hq, 8'h22);
      rd_chk(PMP_STAT_OFS, 32'h0000_0c0e);
      pmp_host_model_inst.host_xfer(1'b0, 2'b01, 8'h00, hq);
      rd_chk(PMP_STAT_OFS, 32'h0000_0c4e);
      // Master write cycle with cycle-end interrupt
      axi_wr(PMP_IRQ_OFS, 32'hf, r);
      axi_wr(PMP_PINEN_OFS, 32'h0000_ffff, r);
      axi_wr(PMP_ADDR_OFS, 32'h0000_c123, r);
      axi_wr(PMP_MODE_OFS, 32'h0000_223c, r);
      axi_wr(PMP_CTRL_OFS, 32'h0000_8018, r);
      axi_wr(PMP_IMASK_OFS, 32'h1, r);
      axi_wr(PMP_MDATA_OFS, 32'h5a, r);
      check(irq, 1'b0);
      axi_wr(PMP_CMD_OFS, 32'h1, r);
      rd_chk(PMP_MODE_OFS, 32'h0000_a23c);
      seen = 16'h0;
      md = 8'h0;
      for (int n = 0; n < 200 && irq !== 1'b1; n++) begin
         @(negedge sys_clk);
         if (write_strobe_pin === 1'b0) begin
            seen = parallel_address_lines;
            md = parallel_data_lines & {8{parallel_data_oe}};
         end
         @(posedge sys_clk);
      end
      check(seen, 16'hc123);
      check(md, 8'h5a);
      check(addr_pin_oe, 16'hffff);
      check(irq, 1'b1);
      rd_chk(PMP_MODE_OFS, 32'h0000_223c);
      axi_wr(PMP_IRQ_OFS, 32'h1, r);
      check(irq, 1'b0);
      // Masked cycle end: status set, line stays low until unmasked
      axi_wr(PMP_IMASK_OFS, 32'h0, r);
      axi_wr(PMP_MODE_OFS, 32'h0000_22c3, r);
      axi_wr(PMP_CMD_OFS, 32'h0, r);
      q = 32'h0;
      for (int n = 0; n < 40 && q[0] !== 1'b1; n++) axi_rd(PMP_IRQ_OFS, q, r);
      check(q, 32'h1);
      check(irq, 1'b0);
      axi_wr(PMP_IMASK_OFS, 32'h1, r);
      check(irq, 1'b1);
      end_of_test();
   end
endmodule
